// ===== hw/rsc_top.sv
// Reset-source control: undervoltage control, reset flags, reset sequencing
//
// How it works
// - Level-select code 5A arms the 2.1 V undervoltage reset, A5 disarms it.
// - Any other level-select code gives a full reset after the soft-reset delay.
// - A reset caused by a bad level-select code reloads the control register with 5A.
// - Undervoltage reset fires only when low supply outlasts the filter time.
// - A true undervoltage reset leaves the control register as it was.
// - Bits 7 to 3 of the reset-source flags always read zero.
// - Flag bit 2 is set by an undervoltage reset and cleared only by writing zero.
// - Flag bit 1 is set by a bad level-select code and cleared only by writing zero.
// - Watchdog expiry while running gives a full reset, sets expiry, keeps power-down.
// - Watchdog expiry asleep clears only PC and SP and sets expiry and power-down.
// - Undervoltage reset while running keeps expiry and power-down flags.
// - Power-on disables interrupts, stops timers and makes every port an input.
// - Power-on sets the PC to zero and the SP to the top of stack.
// - Power-on clears watchdog and time bases, then the watchdog counts at once.
// - Flag bit 0 is set by a watchdog-control soft reset and cleared only by software.
// - Undervoltage reset is disabled while asleep or idle; the code gates it off with sleep_mode only.
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rsc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rsc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rsc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_low,
  input wire logic sleep_mode,
  input wire logic wdt_expiry,
  input wire logic wdt_ctrl_bad,
  input wire logic halt_enter,
  input wire logic wdt_clear_cmd,
  output logic full_reset,
  output logic pcsp_clear,
  output logic irq_disable,
  output logic timers_off,
  output logic ports_input,
  output logic wdt_tb_clear,
  output logic brownout_enable,
  output logic watchdog_expiry_flag,
  output logic powerdown_flag
);
  import rsc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rsc_state_t st_r;
  rsc_state_t st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [7:0] uv_ctrl_r;
  logic [7:0] uv_ctrl_nxt;
  logic [2:0] flags_r;
  logic [2:0] flags_nxt;
  logic expiry_r;
  logic expiry_nxt;
  logic pdown_r;
  logic pdown_nxt;
  logic pend_lvl_r;
  logic pend_wdc_r;
  logic pcsp_r;

  logic aw_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic w_hold_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  logic supply_low_s;
  logic uv_fire;

  // ---------------------------------------------------------------
  // Supply pin and filter
  // ---------------------------------------------------------------
  rsc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(supply_low),
    .sync_out(supply_low_s)
  );

  // Comparator is gated off in sleep so a dip there never resets the core
  wire uv_armed = (uv_ctrl_r == LVS_ENABLE_CODE) && !sleep_mode;

  rsc_lowfilt u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .low_in(supply_low_s),
    .enable(uv_armed),
    .fire(uv_fire)
  );

  // ---------------------------------------------------------------
  // Code checks
  // ---------------------------------------------------------------
  function automatic logic code_valid(input logic [7:0] code);
    return (code == LVS_ENABLE_CODE) || (code == LVS_DISABLE_CODE);
  endfunction

  wire lvl_bad = !code_valid(uv_ctrl_r);
  wire soft_bad = lvl_bad || wdt_ctrl_bad;

  // ---------------------------------------------------------------
  // Reset events
  // ---------------------------------------------------------------
  wire in_run = (st_r == RSC_RUN);
  wire in_wait = (st_r == RSC_WAIT);
  wire in_hold = (st_r == RSC_HOLD);
  wire delay_done = in_wait && (cnt_r == SRESET_DELAY_CYC - CNT_ONE);
  wire hold_done = in_hold && (cnt_r == RESET_HOLD_CYC - CNT_ONE);

  // Undervoltage takes priority over a pending soft reset
  wire ev_uv = uv_fire && !in_hold;
  wire ev_soft = delay_done && !ev_uv;
  wire ev_lvl = ev_soft && pend_lvl_r;
  wire ev_wdc = ev_soft && pend_wdc_r;
  wire ev_wdt_run = wdt_expiry && in_run && !sleep_mode && !ev_uv;
  wire ev_wdt_sleep = wdt_expiry && in_run && sleep_mode && !ev_uv;
  wire start_wait = in_run && soft_bad && !ev_uv && !wdt_expiry;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + CNT_ONE;
    unique case (st_r)
      RSC_RUN: begin
        cnt_nxt = '0;
        if (ev_uv || ev_wdt_run) begin
          st_nxt = RSC_HOLD;
        end else if (start_wait) begin
          st_nxt = RSC_WAIT;
        end
      end
      RSC_WAIT: begin
        if (ev_uv || delay_done) begin
          st_nxt = RSC_HOLD;
          cnt_nxt = '0;
        end
      end
      RSC_HOLD: begin
        if (hold_done) begin
          st_nxt = RSC_RUN;
          cnt_nxt = '0;
        end
      end
      default: begin
        st_nxt = RSC_HOLD;
        cnt_nxt = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_do = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_ctrl = wr_do && (awaddr_r == OFS_UV_CTRL) && wstrb_r[0];
  wire wr_flags = wr_do && (awaddr_r == OFS_RST_FLAGS) && wstrb_r[0];
  wire wr_hit = (awaddr_r == OFS_UV_CTRL) || (awaddr_r == OFS_RST_FLAGS) ||
                (awaddr_r == OFS_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] status_byte = {4'h0, sleep_mode, uv_armed, pdown_r, expiry_r};
  wire rd_ctrl = (s_axi_araddr == OFS_UV_CTRL);
  wire rd_flags = (s_axi_araddr == OFS_RST_FLAGS);
  wire rd_stat = (s_axi_araddr == OFS_STATUS);
  wire [7:0] rd_byte = rd_ctrl ? uv_ctrl_r :
                       rd_flags ? {5'h00, flags_r} :
                       rd_stat ? status_byte : 8'h00;
  wire rd_hit = rd_ctrl || rd_flags || rd_stat;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ---------------------------------------------------------------
  // Undervoltage control register
  // ---------------------------------------------------------------
  // Hardware reload beats a software write in the same cycle
  wire reload_ctrl = ev_lvl || (ev_wdt_run) || (ev_wdc && !ev_lvl);
  assign uv_ctrl_nxt = reload_ctrl ? UV_CTRL_RESET :
                       wr_ctrl ? wdata_r[7:0] : uv_ctrl_r;

  // ---------------------------------------------------------------
  // Reset-source flags: a set beats a clear of the same cycle
  // ---------------------------------------------------------------
  wire [2:0] flag_set;
  wire [2:0] flag_clr;
  assign flag_set[FLG_UV_BIT] = ev_uv;
  assign flag_set[FLG_LVL_BIT] = ev_lvl;
  assign flag_set[FLG_WDC_BIT] = ev_wdc;
  assign flag_clr = wr_flags ? ~wdata_r[2:0] : 3'h0;
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  // ---------------------------------------------------------------
  // Expiry and power-down flags
  // ---------------------------------------------------------------
  // Undervoltage events leave both untouched
  always_comb begin
    expiry_nxt = expiry_r;
    pdown_nxt = pdown_r;
    if (wdt_clear_cmd) begin
      expiry_nxt = 1'b0;
      pdown_nxt = 1'b0;
    end
    if (halt_enter) begin
      expiry_nxt = 1'b0;
      pdown_nxt = 1'b1;
    end
    if (ev_wdt_run) begin
      expiry_nxt = 1'b1;
    end
    if (ev_wdt_sleep) begin
      expiry_nxt = 1'b1;
      pdown_nxt = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= RSC_HOLD;
      cnt_r <= '0;
      uv_ctrl_r <= UV_CTRL_RESET;
      flags_r <= FLAGS_RESET;
      expiry_r <= 1'b0;
      pdown_r <= 1'b0;
      pend_lvl_r <= 1'b0;
      pend_wdc_r <= 1'b0;
      pcsp_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      uv_ctrl_r <= uv_ctrl_nxt;
      flags_r <= flags_nxt;
      expiry_r <= expiry_nxt;
      pdown_r <= pdown_nxt;
      pcsp_r <= ev_wdt_sleep;
      // Cause is caught when the delay starts; a later repair does not cancel it
      if (start_wait) begin
        pend_lvl_r <= lvl_bad;
        pend_wdc_r <= wdt_ctrl_bad;
      end else if (!in_wait) begin
        pend_lvl_r <= 1'b0;
        pend_wdc_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the core
  // ---------------------------------------------------------------
  // Hold state is entered from power-on, so every output below driven from in_hold is active then
  assign full_reset = in_hold;
  assign pcsp_clear = in_hold || pcsp_r;
  assign irq_disable = in_hold;
  assign timers_off = in_hold;
  assign ports_input = in_hold;
  // Released with the hold, so the watchdog restarts on the next edge
  assign wdt_tb_clear = in_hold;
  assign brownout_enable = uv_armed;
  assign watchdog_expiry_flag = expiry_r;
  assign powerdown_flag = pdown_r;

endmodule // rsc_top
`default_nettype wire

// ===== hw/rsc_pkg.sv
// Constants, register map and state codes for the reset-source control block
package rsc_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CNT_W = 12;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_UV_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RST_FLAGS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int FLG_WDC_BIT = 0;
  localparam int FLG_LVL_BIT = 1;
  localparam int FLG_UV_BIT = 2;
  localparam int ST_EXPIRY_BIT = 0;
  localparam int ST_PDOWN_BIT = 1;
  localparam int ST_UV_ARMED_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  localparam logic [7:0] LVS_ENABLE_CODE = 8'h5A;
  localparam logic [7:0] LVS_DISABLE_CODE = 8'hA5;
  localparam logic [7:0] UV_CTRL_RESET = LVS_ENABLE_CODE;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  // ---------------------------------------------------------------
  // AXI responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int UV_FILTER_NS = 100000;
  localparam int SRESET_DELAY_NS = 50000;
  // Least times, rounded up
  localparam logic [CNT_W-1:0] UV_FILTER_CYC =
    CNT_W'((UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SRESET_DELAY_CYC =
    CNT_W'((SRESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_HOLD_CYC = 12'h004;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // ---------------------------------------------------------------
  // Sequencer states, Gray along run -> wait -> hold
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RSC_RUN = 2'h0,
    RSC_WAIT = 2'h1,
    RSC_HOLD = 2'h3
  } rsc_state_t;

endpackage

// ===== hw/rsc_sync.sv
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
`default_nettype none
module rsc_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  logic sync_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // rsc_sync
`default_nettype wire

// ===== hw/rsc_lowfilt.sv
// Low-supply persistence filter: one pulse once low lasts past the filter time
`timescale 1ns/1ps
`default_nettype none
module rsc_lowfilt (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic low_in,
  input wire logic enable,
  output logic fire
);
  import rsc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic fire_r;
  wire active = low_in && enable;
  wire at_limit = (cnt_r == UV_FILTER_CYC);

  // Saturates so one long dip gives one pulse only
  assign cnt_nxt = !active ? '0 : (cnt_r > UV_FILTER_CYC) ? cnt_r : cnt_r + CNT_ONE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      fire_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      fire_r <= active && at_limit;
    end
  end

  assign fire = fire_r;
endmodule // rsc_lowfilt
`default_nettype wire

// ===== tb/rsc_assertions.sv
// Concurrent checks on the reset-source control ports
`timescale 1ns/1ps
`default_nettype none
module rsc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic supply_low,
  input wire logic sleep_mode,
  input wire logic wdt_expiry,
  input wire logic halt_enter,
  input wire logic wdt_clear_cmd,
  input wire logic full_reset,
  input wire logic pcsp_clear,
  input wire logic irq_disable,
  input wire logic timers_off,
  input wire logic ports_input,
  input wire logic wdt_tb_clear,
  input wire logic brownout_enable,
  input wire logic watchdog_expiry_flag,
  input wire logic powerdown_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Length of the current armed low-supply run, saturating
  logic [10:0] low_cnt_r;
  logic [10:0] low_cnt_nxt;
  logic quiet;
  assign low_cnt_nxt = (supply_low && brownout_enable && low_cnt_r != 11'h7FF) ?
    low_cnt_r + 11'h001 : ((supply_low && brownout_enable) ? low_cnt_r : 11'h000);
  assign quiet = !full_reset && !halt_enter && !wdt_clear_cmd;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r <= 11'h000;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end
  sequence s_pcsp_pulse;
    pcsp_clear ##1 !pcsp_clear;
  endsequence
  property p_por;
    $rose(aresetn) |-> (full_reset && irq_disable && pcsp_clear && !watchdog_expiry_flag
      && !powerdown_flag)[*3];
  endproperty
  a_por: assert property (p_por) else $error("power-on state wrong");
  property p_follow;
    irq_disable == full_reset && timers_off == full_reset && ports_input == full_reset
      && wdt_tb_clear == full_reset;
  endproperty
  a_follow: assert property (p_follow) else $error("reset companions differ");
  property p_hold_pc;
    full_reset |-> pcsp_clear;
  endproperty
  a_hold_pc: assert property (p_hold_pc) else $error("pc not cleared in reset");
  property p_run_exp;
    wdt_expiry && !sleep_mode && quiet |=> full_reset && watchdog_expiry_flag
      && powerdown_flag == $past(powerdown_flag);
  endproperty
  a_run_exp: assert property (p_run_exp) else $error("running expiry wrong");
  property p_sleep_exp;
    wdt_expiry && sleep_mode && quiet |=> s_pcsp_pulse
      and (watchdog_expiry_flag && powerdown_flag && !full_reset);
  endproperty
  a_sleep_exp: assert property (p_sleep_exp) else $error("sleep expiry wrong");
  property p_sleep_bo;
    sleep_mode |-> !brownout_enable;
  endproperty
  a_sleep_bo: assert property (p_sleep_bo) else $error("undervoltage armed asleep");
  property p_uv;
    low_cnt_r == 11'h3ED |-> full_reset;
  endproperty
  a_uv: assert property (p_uv) else $error("no undervoltage reset");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer wrong");
endmodule // rsc_chk
bind rsc_top rsc_chk chk_u (.*);
`default_nettype wire

// ===== tb/rsc_env_model.sv
// Supply monitor, watchdog and core events seen by the block
`timescale 1ns/1ps
`default_nettype none
module rsc_env_model (
  input wire logic aclk,
  output logic supply_low,
  output logic sleep_mode,
  output logic wdt_expiry,
  output logic wdt_ctrl_bad,
  output logic halt_enter,
  output logic wdt_clear_cmd
);
  initial {supply_low, sleep_mode, wdt_expiry, wdt_ctrl_bad, halt_enter, wdt_clear_cmd} = 6'h00;
  // One-cycle event: 0 expiry, 1 halt, 2 clear, 3 bad watchdog code
  task automatic pulse(input int sel);
    @(posedge aclk);
    case (sel)
      0: wdt_expiry <= 1'b1;
      1: halt_enter <= 1'b1;
      2: wdt_clear_cmd <= 1'b1;
      default: wdt_ctrl_bad <= 1'b1;
    endcase
    @(posedge aclk);
    {wdt_expiry, halt_enter, wdt_clear_cmd, wdt_ctrl_bad} <= 4'h0;
  endtask
  task automatic low_for(input int n);
    @(posedge aclk);
    supply_low <= 1'b1;
    repeat (n) @(posedge aclk);
    supply_low <= 1'b0;
  endtask
  task automatic sleep(input logic v);
    @(posedge aclk);
    sleep_mode <= v;
  endtask
endmodule // rsc_env_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the reset-source control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import rsc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic supply_low, sleep_mode, wdt_expiry, wdt_ctrl_bad, halt_enter, wdt_clear_cmd;
  logic full_reset, pcsp_clear, irq_disable, timers_off, ports_input, wdt_tb_clear;
  logic brownout_enable, watchdog_expiry_flag, powerdown_flag;
  int num_errors, checks_done, n;
  rsc_top dut_u (.*);
  rsc_env_model env_u (.*);
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;
  // ---------------------------------------------------------------
  // Bus master and helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit aw_hs, w_hs, b_hs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    b_hs = 1'b0;
    while (!b_hs) begin
      // Mid-cycle values are the ones the next edge samples
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    bit ar_hs, r_hs;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_rst(input int lim);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (full_reset !== 1'b1 && n < lim);
    // A limit that runs out is a mismatch of its own
    `CHK("reset seen", 1'b1, full_reset)
    while (full_reset === 1'b1) @(negedge aclk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_por;
    @(negedge aclk);
    `CHK("ports_input", 1'b1, ports_input)
    rd(OFS_UV_CTRL);
    `CHK("ctrl", 32'h0000005A, rv)
    rd(OFS_RST_FLAGS);
    `CHK("flags", 32'h00000000, rv)
    rd(OFS_STATUS);
    `CHK("status", 4'h4, rv[3:0])
    rd(4'hC);
    `CHK("unmapped", RESP_SLVERR, resp)
  endtask
  task automatic t_codes;
    wr(OFS_UV_CTRL, {24'h0, LVS_DISABLE_CODE});
    `CHK("bresp ok", RESP_OKAY, resp)
    `CHK("armed off", 1'b0, brownout_enable)
    wr(OFS_UV_CTRL, {24'h0, LVS_ENABLE_CODE});
    `CHK("armed on", 1'b1, brownout_enable)
    // Lane 0 off: the code must not land
    s_axi_wstrb <= 4'hE;
    wr(OFS_UV_CTRL, {24'h0, LVS_DISABLE_CODE});
    `CHK("lane off", 1'b1, brownout_enable)
    s_axi_wstrb <= 4'hF;
    wr(4'hC, 32'h00000000);
    `CHK("bresp unmapped", RESP_SLVERR, resp)
  endtask
  task automatic t_bad;
    wr(OFS_UV_CTRL, 32'h00000033);
    wait_rst(600);
    `CHK("bad delay", 1'b1, n >= 495 && n <= 505)
    rd(OFS_UV_CTRL);
    `CHK("ctrl reload", 32'h0000005A, rv)
    wr(OFS_RST_FLAGS, 32'h000000FF);
    rd(OFS_RST_FLAGS);
    `CHK("level flag", 32'h00000002, rv)
    wr(OFS_RST_FLAGS, 32'h00000000);
    rd(OFS_RST_FLAGS);
    `CHK("level clear", 32'h00000000, rv)
  endtask
  task automatic t_uv;
    env_u.pulse(1);
    env_u.low_for(900);
    rd(OFS_RST_FLAGS);
    `CHK("short low", 32'h00000000, rv)
    fork
      env_u.low_for(1100);
      wait_rst(1200);
    join
    `CHK("filter", 1'b1, n >= 1000 && n <= 1010)
    rd(OFS_RST_FLAGS);
    `CHK("uv flag", 32'h00000004, rv)
    rd(OFS_UV_CTRL);
    `CHK("ctrl kept", 32'h0000005A, rv)
    `CHK("uv flags", 2'h2, {powerdown_flag, watchdog_expiry_flag})
  endtask
  task automatic t_wdt;
    env_u.pulse(0);
    wait_rst(10);
    `CHK("run expiry", 2'h3, {powerdown_flag, watchdog_expiry_flag})
    rd(OFS_RST_FLAGS);
    `CHK("uv flag kept", 32'h00000004, rv)
  endtask
  task automatic t_sleep;
    env_u.pulse(2);
    env_u.sleep(1'b1);
    @(negedge aclk);
    `CHK("armed asleep", 1'b0, brownout_enable)
    env_u.pulse(0);
    @(negedge aclk);
    `CHK("sleep expiry", 4'hB, {pcsp_clear, full_reset, powerdown_flag, watchdog_expiry_flag})
    env_u.sleep(1'b0);
  endtask
  task automatic t_wdc;
    env_u.pulse(3);
    wait_rst(600);
    `CHK("wdc delay", 1'b1, n >= 495 && n <= 505)
    rd(OFS_RST_FLAGS);
    `CHK("wdc flag", 32'h00000005, rv)
  endtask
  // Power-on again with both status flags set, so the clear is seen
  task automatic t_rst;
    rd(OFS_STATUS);
    `CHK("pre status", 4'h7, rv[3:0])
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK("por outs", 4'hF, {irq_disable, timers_off, ports_input, full_reset})
    `CHK("por pc", 1'b1, pcsp_clear)
    `CHK("por wdt", 1'b1, wdt_tb_clear)
    `CHK("por status", 2'h0, {powerdown_flag, watchdog_expiry_flag})
    wait_rst(10);
    rd(OFS_RST_FLAGS);
    `CHK("por src", 32'h00000000, rv)
  endtask
  task automatic stop_test;
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    num_errors = 0;
    checks_done = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00F;
    s_axi_wdata = 32'h00000000;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_por();
    t_codes();
    t_bad();
    t_uv();
    t_wdt();
    t_sleep();
    t_wdc();
    t_rst();
    stop_test();
  end
  // Whole run is about 3100 cycles
  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
